// File: design/prq_pkg.sv
// Purpose: Shared constants and types for the page request ring block.
// Assumes: 32-bit register port; 64-bit registers split into low and high words.
// Notes: Offsets are byte addresses; the ring itself lives in host memory.
package prq_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRQ_HEAD_LO = 8'hC0;
  localparam logic [7:0] PRQ_HEAD_HI = 8'hC4;
  localparam logic [7:0] PRQ_TAIL_LO = 8'hC8;
  localparam logic [7:0] PRQ_TAIL_HI = 8'hCC;
  localparam logic [7:0] PRQ_BASE_LO = 8'hD0;
  localparam logic [7:0] PRQ_BASE_HI = 8'hD4;
  localparam logic [7:0] PRQ_STATUS = 8'hDC;
  localparam logic [7:0] PRQ_EVCTL = 8'hE0;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int PRQ_OFS_LSB = 5;
  localparam int PRQ_OFS_MSB = 18;
  localparam int PRQ_OFS_W = 14;
  localparam int PRQ_BASE_LSB = 12;
  localparam int PRQ_SIZE_W = 3;
  localparam int PRQ_ST_WAIT = 0;
  localparam int PRQ_ST_OVF = 1;
  localparam int PRQ_EV_MASK = 31;
  localparam int PRQ_EV_PEND = 30;
  localparam int PRQ_ENT_SHIFT = 7;
  localparam logic [PRQ_OFS_W-1:0] PRQ_OFS_RST = 14'h0000;
  localparam logic [2:0] PRQ_SIZE_RST = 3'h0;

  // A page request descriptor is four 64-bit words (32 bytes).
  localparam int PRQ_DESC_W = 256;

  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
  } prq_wr_t;

endpackage : prq_pkg

// File: design/prq_skid.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Ready on the input depends only on registered state.
`timescale 1ns/100ps
module prq_skid #(
  parameter int WIDTH = 256
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : prq_skid

// File: design/prq_ring.sv
// Purpose: Page request ring producer with its software-visible registers.
// Assumes: Host memory writes complete through mem_valid/mem_ready, one 32-byte
//          descriptor per beat; software owns the consumer index.
// Notes: Event delivery only raises evt_msg; message address and data live elsewhere.
`timescale 1ns/100ps
// Operation
// R1: Consumer index in bits 18:5 is software's next entry to consume.
// R2: Producer index in bits 18:5 is next write slot; other bits zero.
// R3: Ring base lives in bits 63:12, always 4KB aligned.
// R4: Base bits at and above the host address width are not kept.
// R5: Software programs the base before enabling page requests.
// R6: Size code X gives 2^(X+7) entries; offsets wrap there.
// R7: Overflow flag, status bit 1, sets when the ring overflows.
// R8: Overflowing message and any while flag set are not queued.
// R9: Overflow raises a page request event subject to event control.
// R10: Writing one clears overflow flag; zero leaves it; reset zero.
// R11: Waiting flag, status bit 0, sets per descriptor added; W1C.
// R12: Without feature support all ring registers read zero, ignore writes.
// R13: New event only if neither flag set; message only when unmasked.
// R14: Advance producer index per descriptor; full when next equals consumer.
module prq_ring
  import prq_pkg::*;
#(
  parameter int HOST_ADDR_W = 48,
  parameter bit FEATURE_ON = 1'b1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [PRQ_DESC_W-1:0] req_desc,
  output logic req_dropped,
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [63:0] mem_addr,
  output logic [PRQ_DESC_W-1:0] mem_data,
  output logic evt_msg
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Offsets are stored at full width and masked on every step, so a new size
  // code never forces the stored indices to be rewritten.
  function automatic logic [PRQ_OFS_W-1:0] ofs_mask(input logic [2:0] code);
    logic [PRQ_OFS_W-1:0] m;
    m = '1;
    m = m >> (3'h7 - code);
    return m;
  endfunction : ofs_mask

  function automatic logic [PRQ_OFS_W-1:0] ofs_inc(input logic [PRQ_OFS_W-1:0] v,
                                                   input logic [2:0] code);
    return (v + 14'h0001) & ofs_mask(code);
  endfunction : ofs_inc

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [PRQ_OFS_W-1:0] head_ff;
  logic [PRQ_OFS_W-1:0] tail_ff;
  logic [51:0] base_ff;
  logic [2:0] size_ff;
  logic wait_ff;
  logic ovf_ff;
  logic mask_ff;
  logic pend_ff;
  logic [31:0] rdata_ff;
  logic drop_ff;
  logic evt_ff;
  logic [63:0] addr_ff;
  logic wr_en;
  logic [31:0] rd_word;
  logic [63:0] base_mask;
  logic [PRQ_OFS_W-1:0] tail_next;
  logic full;
  logic take;
  logic enq;
  logic drop;
  logic buf_ready;
  logic set_wait;
  logic set_ovf;
  logic clr_wait;
  logic clr_ovf;
  logic new_event;
  logic [PRQ_DESC_W-1:0] buf_desc;
  logic [63:0] buf_addr;

  // R12 gated access
  assign wr_en = reg_wr && FEATURE_ON;

  // R4 implemented base bits
  assign base_mask = (HOST_ADDR_W >= 64) ? '1 : ((64'h1 << HOST_ADDR_W) - 64'h1);

  // R14 full detect
  // One slot always stays empty, so equal indices can only mean an empty ring.
  assign tail_next = ofs_inc(tail_ff, size_ff);
  assign full = (tail_next == head_ff);

  // The buffer always drains toward memory, so back-pressure stalls intake
  // instead of dropping; only ring-full or the overflow flag drop requests.
  assign take = req_valid && req_ready;
  // R8 block while overflowed
  assign enq = take && !full && !ovf_ff;
  assign drop = take && (full || ovf_ff);
  assign set_wait = enq;
  // R7 detect overflow
  assign set_ovf = take && full && !ovf_ff;
  assign clr_wait = wr_en && (reg_addr == PRQ_STATUS) && reg_wdata[PRQ_ST_WAIT];
  assign clr_ovf = wr_en && (reg_addr == PRQ_STATUS) && reg_wdata[PRQ_ST_OVF];
  // R13 new event condition
  assign new_event = (set_wait || set_ovf) && !wait_ff && !ovf_ff;
  assign req_ready = buf_ready && FEATURE_ON;
  assign buf_addr = ({base_ff, 12'h000} & base_mask) +
                    {45'h0, tail_ff, 5'h00};

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Head and tail writes are not masked to the ring size; software must keep
  // them inside the ring that it programmed.
  // R1 consumer index
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      head_ff <= PRQ_OFS_RST;
    end else if (wr_en && reg_addr == PRQ_HEAD_LO) begin
      head_ff <= reg_wdata[PRQ_OFS_MSB:PRQ_OFS_LSB];
    end
  end

  // R2 producer index
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tail_ff <= PRQ_OFS_RST;
    end else if (enq) begin
      // R14 advance producer
      tail_ff <= tail_next;
    end else if (wr_en && reg_addr == PRQ_TAIL_LO) begin
      tail_ff <= reg_wdata[PRQ_OFS_MSB:PRQ_OFS_LSB];
    end
  end

  // R3 base and size
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      base_ff <= '0;
      size_ff <= PRQ_SIZE_RST;
    end else if (wr_en && reg_addr == PRQ_BASE_LO) begin
      base_ff[19:0] <= reg_wdata[31:PRQ_BASE_LSB];
      // R6 size code
      size_ff <= reg_wdata[PRQ_SIZE_W-1:0];
    end else if (wr_en && reg_addr == PRQ_BASE_HI) begin
      base_ff[51:20] <= reg_wdata;
    end
  end

  // Set wins over a clear in the same cycle.
  // R11 waiting flag
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wait_ff <= 1'b0;
    end else if (set_wait) begin
      wait_ff <= 1'b1;
    end else if (clr_wait) begin
      wait_ff <= 1'b0;
    end
  end

  // R10 overflow clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ovf_ff <= 1'b0;
    end else if (set_ovf) begin
      ovf_ff <= 1'b1;
    end else if (clr_ovf) begin
      ovf_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Event control
  // ----------------------------------------------------------------------
  // R9 raise event
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mask_ff <= 1'b1;
      pend_ff <= 1'b0;
      evt_ff <= 1'b0;
    end else begin
      if (wr_en && reg_addr == PRQ_EVCTL) begin
        mask_ff <= reg_wdata[PRQ_EV_MASK];
      end
      evt_ff <= 1'b0;
      // R13 mask gates message
      if (new_event || pend_ff) begin
        if (!mask_ff) begin
          evt_ff <= 1'b1;
          pend_ff <= 1'b0;
        end else begin
          pend_ff <= 1'b1;
        end
      end
      // A new event beats a software clear that lands in the same cycle.
      if (pend_ff && clr_wait && !new_event) begin
        pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      drop_ff <= 1'b0;
    end else begin
      drop_ff <= drop;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (reg_addr)
      PRQ_HEAD_LO: rd_word[PRQ_OFS_MSB:PRQ_OFS_LSB] = head_ff;
      PRQ_TAIL_LO: rd_word[PRQ_OFS_MSB:PRQ_OFS_LSB] = tail_ff;
      PRQ_BASE_LO: rd_word = {base_ff[19:0] & base_mask[31:12], 9'h000, size_ff};
      PRQ_BASE_HI: rd_word = base_ff[51:20] & base_mask[63:32];
      PRQ_STATUS: rd_word = {30'h0, ovf_ff, wait_ff};
      PRQ_EVCTL: rd_word = {mask_ff, pend_ff, 30'h0};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // R12 reads zero
  // Outside a read strobe the data port returns zero, so stale data never lingers.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd && FEATURE_ON) begin
      rdata_ff <= rd_word;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Memory path
  // ----------------------------------------------------------------------
  logic [PRQ_DESC_W+63:0] skid_out;
  logic skid_valid;
  prq_skid #(.WIDTH(PRQ_DESC_W + 64)) u_skid (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(enq),
    .in_ready(buf_ready),
    .in_data({buf_addr, req_desc}),
    .out_valid(skid_valid),
    .out_ready(!mem_valid || mem_ready),
    .out_data(skid_out)
  );

  // The output register stalls on mem_ready alone; the buffer absorbs the
  // request already in flight, so a slow memory never loses a descriptor.
  logic [PRQ_DESC_W-1:0] data_ff;
  logic mvalid_ff;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mvalid_ff <= 1'b0;
      addr_ff <= 64'h0;
      data_ff <= '0;
    end else if (!mvalid_ff || mem_ready) begin
      mvalid_ff <= skid_valid;
      if (skid_valid) begin
        addr_ff <= skid_out[PRQ_DESC_W+63:PRQ_DESC_W];
        data_ff <= skid_out[PRQ_DESC_W-1:0];
      end
    end
  end

  assign buf_desc = data_ff;
  assign mem_valid = mvalid_ff;
  assign mem_addr = addr_ff;
  assign mem_data = buf_desc;
  assign reg_rdata = rdata_ff;
  assign req_dropped = drop_ff;
  assign evt_msg = evt_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  overflow_set_a: assert property (@(posedge mclk) disable iff (!reset_n) // R7
    set_ovf |=> ovf_ff) else $error("overflow flag not set");
  no_enq_ovf_a: assert property (@(posedge mclk) disable iff (!reset_n) // R8
    ovf_ff |-> !enq) else $error("enqueued while overflowed");
  tail_adv_a: assert property (@(posedge mclk) disable iff (!reset_n) // R14
    enq |=> tail_ff == ofs_inc($past(tail_ff), $past(size_ff)))
    else $error("tail not advanced");
  wait_set_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
    enq |=> wait_ff) else $error("waiting flag not set");
  ovf_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // R10
    ovf_ff && !clr_ovf |=> ovf_ff) else $error("overflow lost without clear");
  masked_evt_a: assert property (@(posedge mclk) disable iff (!reset_n) // R13
    mask_ff |=> !evt_ff) else $error("message sent while masked");
  tail_wrap_a: assert property (@(posedge mclk) disable iff (!reset_n) // R6
    enq |=> (tail_ff & ~ofs_mask($past(size_ff))) == 14'h0000)
    else $error("tail beyond ring");
  ovf_event_a: assert property (@(posedge mclk) disable iff (!reset_n) // R9
    set_ovf && !wait_ff && !mask_ff |=> evt_ff) else $error("no event on overflow");
  mem_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // R14
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_data))
    else $error("memory write changed while stalled");
  no_drop_a: assert property (@(posedge mclk) disable iff (!reset_n) // R8
    !drop |=> !req_dropped)
    else $error("drop reported without a drop");
  ovf_drop_a: assert property (@(posedge mclk) disable iff (!reset_n) // R8
    take && ovf_ff |=> req_dropped)
    else $error("request kept while overflowed");
  wait_clr_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
    clr_wait && !set_wait |=> !wait_ff)
    else $error("waiting flag not cleared");
  ovf_clr_a: assert property (@(posedge mclk) disable iff (!reset_n) // R10
    clr_ovf && !set_ovf |=> !ovf_ff)
    else $error("overflow flag not cleared");
  evt_send_a: assert property (@(posedge mclk) disable iff (!reset_n) // R13
    new_event && !mask_ff |=> evt_ff)
    else $error("unmasked event not sent");
  evt_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // R13
    new_event && mask_ff |=> pend_ff)
    else $error("masked event not held pending");
  no_feature_a: assert property (@(posedge mclk) disable iff (!reset_n) // R12
    !FEATURE_ON |-> reg_rdata == 32'h0000_0000 && !req_ready)
    else $error("ring visible without feature support");
  tail_hi_a: assert property (@(posedge mclk) disable iff (!reset_n) // R2
    reg_rd && reg_addr == PRQ_TAIL_HI |=> reg_rdata == 32'h0000_0000)
    else $error("upper tail word not zero");
  base_cut_a: assert property (@(posedge mclk) disable iff (!reset_n) // R4
    reg_rd && reg_addr == PRQ_BASE_HI |=> (reg_rdata & ~base_mask[63:32]) == 32'h0000_0000)
    else $error("base bits above address width kept");

endmodule : prq_ring

// File: test/prq_host_mem.sv
// Purpose: Host memory stand-in that takes descriptor writes from the ring.
// Assumes: One write per beat with mem_valid and mem_ready both high.
// Notes: With slow set it accepts only on alternate cycles.
`timescale 1ns/100ps
module prq_host_mem
  import prq_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic mem_valid,
  output logic mem_ready,
  input wire logic [63:0] mem_addr,
  input wire logic [PRQ_DESC_W-1:0] mem_data,
  output int n_wr,
  output logic [63:0] last_addr,
  output logic [PRQ_DESC_W-1:0] last_data
);
  // A stalling memory makes the producer hold its write steady.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mem_ready <= 1'b0;
      n_wr <= 0;
    end else begin
      mem_ready <= slow ? ~mem_ready : 1'b1;
      if (mem_valid && mem_ready) begin
        n_wr <= n_wr + 1;
        last_addr <= mem_addr;
        last_data <= mem_data;
      end
    end
  end
endmodule : prq_host_mem

// File: test/tb_top.sv
// Purpose: Self-checking bench for the page request ring.
// Assumes: Host memory model on the write side.
// Notes: Ring size code 0 gives 128 entries.
`timescale 1ns/100ps
module tb_top;
  import prq_pkg::*;
  logic mclk, reset_n, reg_wr, reg_rd, req_valid, slow;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [PRQ_DESC_W-1:0] req_desc, mem_data, last_data;
  logic req_ready, req_dropped, mem_valid, mem_ready, evt_msg;
  logic [63:0] mem_addr, last_addr;
  logic [31:0] off_rdata;
  logic off_ready;
  int n_fail = 0, n_checks = 0, n_evt = 0, n_wr, cyc = 0;

  prq_ring #(.HOST_ADDR_W(48), .FEATURE_ON(1'b1)) DUT (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req_ready(req_ready),
    .req_desc(req_desc), .req_dropped(req_dropped), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_data(mem_data), .evt_msg(evt_msg));
  // Second copy built without feature support sees the same register traffic.
  prq_ring #(.HOST_ADDR_W(48), .FEATURE_ON(1'b0)) DUT_off (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(off_rdata), .req_valid(req_valid), .req_ready(off_ready),
    .req_desc(req_desc), .req_dropped(), .mem_valid(), .mem_ready(1'b1), .mem_addr(),
    .mem_data(), .evt_msg());
  prq_host_mem mem_u (.mclk(mclk), .reset_n(reset_n), .slow(slow), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_data(mem_data), .n_wr(n_wr),
    .last_addr(last_addr), .last_data(last_data));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (evt_msg === 1'b1) n_evt <= n_evt + 1;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk({32'h0, reg_rdata}, {32'h0, exp});
  endtask : rd

  // Offers one descriptor, then judges the drop pulse and the memory write.
  task automatic send(input logic [63:0] d, input logic drop, input logic [63:0] exp_addr);
    int n0;
    bit ok;
    n0 = n_wr;
    ok = 1'b0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_desc <= {4{d}};
    for (int i = 0; i < 40 && !ok; i++) begin
      #1 ok = req_ready;
      @(posedge mclk);
    end
    req_valid <= 1'b0;
    #1 chk({63'h0, req_dropped}, {63'h0, drop});
    for (int i = 0; i < 40 && n_wr == n0; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(64'(n_wr - n0), {63'h0, !drop});
    if (!drop) begin
      chk(last_addr, exp_addr);
      chk(last_data[255:192], d);
    end
  endtask : send

  task automatic evt(input int exp);
    repeat (6) @(posedge mclk);
    #1 chk(64'(n_evt), 64'(exp));
  endtask : evt

  task automatic t_reset();
    logic [7:0] a[8] = '{8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hDC, 8'hF0};
    foreach (a[i]) rd(a[i], 32'h0);
    rd(PRQ_EVCTL, 32'h8000_0000);
    chk({32'h0, off_rdata}, 64'h0);
    chk({63'h0, off_ready}, 64'h0);
  endtask : t_reset

  task automatic t_base();
    wr(PRQ_BASE_LO, 32'hFFFF_FFFF);
    rd(PRQ_BASE_LO, 32'hFFFF_F007);
    chk({32'h0, off_rdata}, 64'h0);
    wr(PRQ_BASE_HI, 32'hFFFF_FFFF);
    rd(PRQ_BASE_HI, 32'h0000_FFFF);
    wr(PRQ_HEAD_LO, 32'hFFFF_FFFF);
    rd(PRQ_HEAD_LO, 32'h0007_FFE0);
    wr(PRQ_TAIL_HI, 32'hFFFF_FFFF);
    rd(PRQ_TAIL_HI, 32'h0);
    wr(PRQ_HEAD_LO, 32'h0);
    wr(PRQ_BASE_HI, 32'h1);
    wr(PRQ_BASE_LO, 32'h5000);
    wr(PRQ_EVCTL, 32'h0);
  endtask : t_base

  task automatic t_enq();
    send(64'h11, 1'b0, 64'h1_0000_5000);
    rd(PRQ_TAIL_LO, 32'h20);
    rd(PRQ_STATUS, 32'h1);
    evt(1);
    slow <= 1'b1;
    send(64'h22, 1'b0, 64'h1_0000_5020);
    evt(1);
    slow <= 1'b0;
  endtask : t_enq

  task automatic t_ovf();
    wr(PRQ_STATUS, 32'h1);
    wr(PRQ_TAIL_LO, 32'hFC0);
    send(64'h33, 1'b0, 64'h1_0000_5FC0);
    evt(2);
    wr(PRQ_STATUS, 32'h1);
    send(64'h44, 1'b1, 64'h0);
    rd(PRQ_STATUS, 32'h2);
    evt(3);
    wr(PRQ_STATUS, 32'h0);
    rd(PRQ_STATUS, 32'h2);
    wr(PRQ_HEAD_LO, 32'hA0);
    send(64'h55, 1'b1, 64'h0);
    wr(PRQ_STATUS, 32'h2);
    rd(PRQ_STATUS, 32'h0);
    send(64'h66, 1'b0, 64'h1_0000_5FE0);
    rd(PRQ_TAIL_LO, 32'h0);
    evt(4);
  endtask : t_ovf

  // Streams six descriptors into a memory that takes every other beat, so the
  // buffer must push back without losing a word.
  task automatic t_burst();
    int n0;
    int taken;
    bit rdy;
    bit low;
    n0 = n_wr;
    taken = 0;
    low = 1'b0;
    wr(PRQ_HEAD_LO, 32'h0);
    @(posedge mclk);
    slow <= 1'b1;
    req_valid <= 1'b1;
    req_desc <= {4{64'h70}};
    for (int i = 0; i < 60 && taken < 6; i++) begin
      #1 rdy = req_ready;
      low = low | !rdy;
      @(posedge mclk);
      if (rdy) begin
        taken++;
        req_desc <= {4{64'h70 + 64'(taken)}};
      end
    end
    req_valid <= 1'b0;
    slow <= 1'b0;
    for (int i = 0; i < 60 && n_wr - n0 < 6; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(64'(n_wr - n0), 64'h6);
    chk(last_addr, 64'h1_0000_50A0);
    chk(last_data[255:192], 64'h75);
    chk({63'h0, low}, 64'h1);
    rd(PRQ_TAIL_LO, 32'hC0);
    evt(4);
  endtask : t_burst

  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req_valid = 1'b0;
    slow = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    req_desc = '0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_base();
    t_enq();
    t_ovf();
    t_burst();
    give_verdict();
  end
endmodule : tb_top
